// ### inc/mpc_pkg.sv
// Constants, register map and carrier types of the master and programmable clock block
package mpc_pkg;

    // Register byte addresses
    localparam logic [31:0] MCK_CFG_ADDR = 32'h0FFF_FC30;
    localparam logic [31:0] PCK_CFG_ADDR = 32'h0FFF_FC40;
    localparam logic [31:0] IRQ_SET_ADDR = 32'h0FFF_FC60;
    localparam logic [31:0] IRQ_CLR_ADDR = 32'h0FFF_FC64;
    localparam logic [31:0] STATUS_ADDR = 32'h0FFF_FC68;
    localparam logic [31:0] MASK_VIEW_ADDR = 32'h0FFF_FC6C;
    localparam logic [31:0] PUMP_ADDR = 32'h0FFF_FC80;
    localparam logic [31:0] OSC_CTRL_ADDR = 32'h0FFF_FC90;
    localparam logic [31:0] PLL_A_CFG_ADDR = 32'h0FFF_FC94;
    localparam logic [31:0] PLL_B_CFG_ADDR = 32'h0FFF_FC98;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;

    // Writable bits of each stored register
    localparam logic [31:0] MCK_WMASK = 32'h0000_031F;
    localparam logic [31:0] PCK_WMASK = 32'h0000_001F;
    localparam logic [31:0] PUMP_WMASK = 32'h0001_0001;
    localparam logic [31:0] OSC_WMASK = 32'h0000_FF01;
    localparam logic [31:0] PLL_WMASK = 32'h0000_3F00;
    localparam logic [31:0] IRQ_WMASK = 32'h0000_0F0F;

    // Reset values
    localparam logic [31:0] MCK_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PCK_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] PUMP_RST = 32'h0000_0000;
    localparam logic [31:0] OSC_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] PLL_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] IRQ_EN_RST = 32'h0000_0000;

    // Field positions
    localparam int ST_MAIN_OSC = 0;
    localparam int ST_PLL_A = 1;
    localparam int ST_PLL_B = 2;
    localparam int ST_MCK_RDY = 3;
    localparam int ST_PCK_LSB = 8;
    localparam int PUMP_A_BIT = 0;
    localparam int PUMP_B_BIT = 16;
    localparam int OSC_EN_BIT = 0;
    localparam int OSC_COUNT_LSB = 8;
    localparam int OSC_COUNT_W = 8;
    localparam int OSC_UNIT_SHIFT = 3;
    localparam int PLL_COUNT_LSB = 8;
    localparam int PLL_COUNT_W = 6;

    // Divider codes
    localparam logic [2:0] DIV_RESERVED = 3'h7;
    localparam logic [1:0] MASTER_DIVIDE_RESERVED = 2'h3;
    localparam int NUM_PCK = 4;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [1:0] master_divide;
        logic [2:0] unused;
        logic [2:0] prescaler_select;
        logic [1:0] clock_source_select;
    } mpc_mck_cfg_t;

    typedef struct packed {
        logic [2:0] prescaler_select;
        logic [1:0] clock_source_select;
    } mpc_pck_cfg_t;

    typedef struct packed {
        logic pll_b_clk;
        logic pll_a_clk;
        logic main_clk;
        logic slow_clk;
    } mpc_src_t;

    function automatic logic [31:0] mpc_strb_mask(input logic [3:0] strb);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
        return m;
    endfunction

endpackage

// ### src/mpc_clkdiv.sv
// Power-of-two clock divider with restart and ready tracking
`timescale 1ns/1ps
`default_nettype none
module mpc_clkdiv #(
    parameter int CNT_W = 6
) (
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic src_level,
    input wire logic restart,
    input wire logic [2:0] div_code,
    output logic clk_out,
    output logic ready
);
    logic src_d_reg, src_d_next;
    logic [CNT_W-1:0] cnt_reg, cnt_next;
    logic out_reg, out_next;
    logic ready_reg, ready_next;
    logic valid;

    always_comb begin
        valid = (int'(div_code) <= CNT_W);
        src_d_next = src_level;
        cnt_next = cnt_reg;
        if (restart) begin
            cnt_next = '0;
        end else if (src_level && !src_d_reg) begin
            cnt_next = cnt_reg + 1'b1;
        end
        // Reserved code holds low
        if (restart || !valid) begin
            out_next = 1'b0;
        end else if (div_code == 3'h0) begin
            out_next = src_level;
        end else begin
            out_next = cnt_next[int'(div_code) - 1];
        end
        ready_next = !restart && (ready_reg || (valid && out_next && !out_reg));
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            src_d_reg <= 1'b0;
            cnt_reg <= '0;
            out_reg <= 1'b0;
            ready_reg <= 1'b0;
        end else begin
            src_d_reg <= src_d_next;
            cnt_reg <= cnt_next;
            out_reg <= out_next;
            ready_reg <= ready_next;
        end
    end

    assign clk_out = out_reg;
    assign ready = ready_reg;
endmodule
`default_nettype wire

// ### src/mpc_top.sv
// Master clock selection, programmable clocks and clock status with AXI4-Lite registers
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Master source select 00 slow, 01 main, 10 PLL A, 11 PLL B.
// - Processor prescaler divides by 1 to 64 in powers of two; code 7 reserved.
// - Master divide 1, 2 or 4 from processor clock; code 3 reserved.
// - Each programmable clock has own source select and 1-to-64 prescaler.
// - Writing 1 to enable-set register enables that interrupt; 0 no effect.
// - Writing 1 to enable-clear register disables that interrupt; 0 no effect.
// - Mask view reads 0 for enabled, 1 for disabled interrupt.
// - Status bit 0 oscillator stable, 1/2 PLL locks, 3 master ready.
// - Status bits 8 to 11 programmable clock ready; same layout for interrupts.
// - Oscillator stable after startup count times 8 slow clock cycles.
// - PLL lock flag sets programmed slow cycles after its config write.
module mpc_top
    import mpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire mpc_pkg::mpc_src_t src_in,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic proc_clk_out,
    output logic master_clk_out,
    output logic [3:0] prog_clk_out,
    output logic main_osc_enable,
    output logic pll_a_pump_current,
    output logic pll_b_pump_current,
    output logic irq
);
    // Bus slave state
    logic aw_hold_reg, aw_hold_next;
    logic w_hold_reg, w_hold_next;
    logic [31:0] awaddr_reg, awaddr_next;
    logic [31:0] wdata_reg, wdata_next;
    logic [3:0] wstrb_reg, wstrb_next;
    logic bvalid_reg, bvalid_next;
    logic [1:0] bresp_reg, bresp_next;
    logic rvalid_reg, rvalid_next;
    logic [31:0] rdata_reg, rdata_next;
    logic [1:0] rresp_reg, rresp_next;

    // Configuration registers
    logic [31:0] mck_cfg_reg, mck_cfg_next;
    logic [31:0] pck_cfg_reg [NUM_PCK];
    logic [31:0] pck_cfg_next [NUM_PCK];
    logic [31:0] pump_reg, pump_next;
    logic [31:0] osc_ctrl_reg, osc_ctrl_next;
    logic [31:0] pll_cfg_reg [2];
    logic [31:0] pll_cfg_next [2];
    logic [31:0] irq_en_reg, irq_en_next;

    // Status state
    logic slow_d_reg, slow_d_next;
    logic [OSC_COUNT_W+OSC_UNIT_SHIFT-1:0] osc_cnt_reg, osc_cnt_next;
    logic osc_stable_reg, osc_stable_next;
    logic [PLL_COUNT_W-1:0] pll_cnt_reg [2];
    logic [PLL_COUNT_W-1:0] pll_cnt_next [2];
    logic [1:0] pll_lock_reg, pll_lock_next;

    logic wr_fire, slow_rise, mck_restart, proc_rdy, mst_rdy;
    logic [3:0] pck_restart, pck_rdy;
    logic [31:0] wmask, status_word, rd_word;
    logic rd_hit;
    logic [3:0] src_vec;
    mpc_mck_cfg_t mck_view;
    mpc_pck_cfg_t pck_view [NUM_PCK];
    logic [2:0] master_divide_code;

    assign src_vec = src_in;
    assign mck_view = mpc_mck_cfg_t'(mck_cfg_reg[9:0]);
    assign wr_fire = aw_hold_reg && w_hold_reg && !bvalid_reg;
    assign wmask = mpc_strb_mask(wstrb_reg);
    assign slow_rise = src_in.slow_clk && !slow_d_reg;

    // AXI4-Lite handshakes and register writes
    always_comb begin
        aw_hold_next = aw_hold_reg;
        w_hold_next = w_hold_reg;
        awaddr_next = awaddr_reg;
        wdata_next = wdata_reg;
        wstrb_next = wstrb_reg;
        bvalid_next = bvalid_reg;
        bresp_next = bresp_reg;
        mck_cfg_next = mck_cfg_reg;
        pck_cfg_next = pck_cfg_reg;
        pump_next = pump_reg;
        osc_ctrl_next = osc_ctrl_reg;
        pll_cfg_next = pll_cfg_reg;
        irq_en_next = irq_en_reg;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_next = 1'b1;
            awaddr_next = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_hold_next = 1'b1;
            wdata_next = s_axi_wdata;
            wstrb_next = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_next = 1'b0;
        end
        if (wr_fire) begin
            aw_hold_next = 1'b0;
            w_hold_next = 1'b0;
            bvalid_next = 1'b1;
            bresp_next = RESP_OKAY;
            case (awaddr_reg)
                MCK_CFG_ADDR: begin
                    mck_cfg_next = (mck_cfg_reg & ~(wmask & MCK_WMASK)) | (wdata_reg & wmask & MCK_WMASK);
                end
                IRQ_SET_ADDR: begin
                    irq_en_next = irq_en_reg | (wdata_reg & wmask & IRQ_WMASK);
                end
                IRQ_CLR_ADDR: begin
                    irq_en_next = irq_en_reg & ~(wdata_reg & wmask & IRQ_WMASK);
                end
                PUMP_ADDR: begin
                    pump_next = (pump_reg & ~(wmask & PUMP_WMASK)) | (wdata_reg & wmask & PUMP_WMASK);
                end
                OSC_CTRL_ADDR: begin
                    osc_ctrl_next = (osc_ctrl_reg & ~(wmask & OSC_WMASK)) | (wdata_reg & wmask & OSC_WMASK);
                end
                PLL_A_CFG_ADDR: begin
                    pll_cfg_next[0] = (pll_cfg_reg[0] & ~(wmask & PLL_WMASK)) | (wdata_reg & wmask & PLL_WMASK);
                end
                PLL_B_CFG_ADDR: begin
                    pll_cfg_next[1] = (pll_cfg_reg[1] & ~(wmask & PLL_WMASK)) | (wdata_reg & wmask & PLL_WMASK);
                end
                STATUS_ADDR, MASK_VIEW_ADDR: begin
                    bresp_next = RESP_OKAY;
                end
                default: begin
                    bresp_next = RESP_SLVERR;
                    for (int i = 0; i < NUM_PCK; i++) begin
                        if (awaddr_reg == PCK_CFG_ADDR + WORD_STEP * 32'(i)) begin
                            bresp_next = RESP_OKAY;
                            pck_cfg_next[i] = (pck_cfg_reg[i] & ~(wmask & PCK_WMASK))
                                | (wdata_reg & wmask & PCK_WMASK);
                        end
                    end
                end
            endcase
        end
    end

    always_comb begin
        mck_restart = (mck_cfg_next != mck_cfg_reg);
        for (int i = 0; i < NUM_PCK; i++) begin
            pck_restart[i] = (pck_cfg_next[i] != pck_cfg_reg[i]);
        end
    end

    // Oscillator and PLL status
    always_comb begin
        slow_d_next = src_in.slow_clk;
        osc_cnt_next = osc_cnt_reg;
        osc_stable_next = osc_stable_reg;
        pll_cnt_next = pll_cnt_reg;
        pll_lock_next = pll_lock_reg;
        if (!osc_ctrl_reg[OSC_EN_BIT]) begin
            osc_cnt_next = '0;
            osc_stable_next = 1'b0;
        end else if (!osc_stable_reg) begin
            if (osc_cnt_reg >= {osc_ctrl_reg[OSC_COUNT_LSB +: OSC_COUNT_W], {OSC_UNIT_SHIFT{1'b0}}}) begin
                osc_stable_next = 1'b1;
            end else if (slow_rise) begin
                osc_cnt_next = osc_cnt_reg + 1'b1;
            end
        end
        for (int p = 0; p < 2; p++) begin
            if (pll_cfg_next[p] != pll_cfg_reg[p] || (wr_fire && awaddr_reg == (p == 0 ? PLL_A_CFG_ADDR
                : PLL_B_CFG_ADDR))) begin
                pll_cnt_next[p] = pll_cfg_next[p][PLL_COUNT_LSB +: PLL_COUNT_W];
                pll_lock_next[p] = 1'b0;
            end else if (!pll_lock_reg[p]) begin
                if (pll_cnt_reg[p] == '0) begin
                    pll_lock_next[p] = 1'b1;
                end else if (slow_rise) begin
                    pll_cnt_next[p] = pll_cnt_reg[p] - 1'b1;
                end
            end
        end
    end

    always_comb begin
        status_word = '0;
        status_word[ST_MAIN_OSC] = osc_stable_reg;
        status_word[ST_PLL_A] = pll_lock_reg[0];
        status_word[ST_PLL_B] = pll_lock_reg[1];
        status_word[ST_MCK_RDY] = proc_rdy && mst_rdy;
        status_word[ST_PCK_LSB +: NUM_PCK] = pck_rdy;
    end

    // Read decode
    always_comb begin
        rd_hit = 1'b1;
        rd_word = '0;
        case (s_axi_araddr)
            MCK_CFG_ADDR: rd_word = mck_cfg_reg;
            STATUS_ADDR: rd_word = status_word;
            MASK_VIEW_ADDR: rd_word = ~irq_en_reg & IRQ_WMASK;
            PUMP_ADDR: rd_word = pump_reg;
            OSC_CTRL_ADDR: rd_word = osc_ctrl_reg;
            PLL_A_CFG_ADDR: rd_word = pll_cfg_reg[0];
            PLL_B_CFG_ADDR: rd_word = pll_cfg_reg[1];
            IRQ_SET_ADDR, IRQ_CLR_ADDR: rd_word = '0;
            default: begin
                rd_hit = 1'b0;
                for (int i = 0; i < NUM_PCK; i++) begin
                    if (s_axi_araddr == PCK_CFG_ADDR + WORD_STEP * 32'(i)) begin
                        rd_hit = 1'b1;
                        rd_word = pck_cfg_reg[i];
                    end
                end
            end
        endcase
        rvalid_next = rvalid_reg;
        rdata_next = rdata_reg;
        rresp_next = rresp_reg;
        if (s_axi_rvalid && s_axi_rready) begin
            rvalid_next = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_next = 1'b1;
            rdata_next = rd_word;
            rresp_next = rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!nrst) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
            mck_cfg_reg <= MCK_CFG_RST;
            for (int i = 0; i < NUM_PCK; i++) begin
                pck_cfg_reg[i] <= PCK_CFG_RST;
            end
            pump_reg <= PUMP_RST;
            osc_ctrl_reg <= OSC_CTRL_RST;
            pll_cfg_reg[0] <= PLL_CFG_RST;
            pll_cfg_reg[1] <= PLL_CFG_RST;
            irq_en_reg <= IRQ_EN_RST;
            slow_d_reg <= 1'b0;
            osc_cnt_reg <= '0;
            osc_stable_reg <= 1'b0;
            pll_cnt_reg[0] <= '0;
            pll_cnt_reg[1] <= '0;
            pll_lock_reg <= '0;
        end else begin
            aw_hold_reg <= aw_hold_next;
            w_hold_reg <= w_hold_next;
            awaddr_reg <= awaddr_next;
            wdata_reg <= wdata_next;
            wstrb_reg <= wstrb_next;
            bvalid_reg <= bvalid_next;
            bresp_reg <= bresp_next;
            rvalid_reg <= rvalid_next;
            rdata_reg <= rdata_next;
            rresp_reg <= rresp_next;
            mck_cfg_reg <= mck_cfg_next;
            pck_cfg_reg <= pck_cfg_next;
            pump_reg <= pump_next;
            osc_ctrl_reg <= osc_ctrl_next;
            pll_cfg_reg <= pll_cfg_next;
            irq_en_reg <= irq_en_next;
            slow_d_reg <= slow_d_next;
            osc_cnt_reg <= osc_cnt_next;
            osc_stable_reg <= osc_stable_next;
            pll_cnt_reg <= pll_cnt_next;
            pll_lock_reg <= pll_lock_next;
        end
    end

    // reserved divide code maps to reserved
    assign master_divide_code = (mck_view.master_divide == MASTER_DIVIDE_RESERVED) ? DIV_RESERVED
        : {1'b0, mck_view.master_divide};

    mpc_clkdiv #(.CNT_W(6)) u_proc_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .src_level(src_vec[mck_view.clock_source_select]),
        .restart(mck_restart),
        .div_code(mck_view.prescaler_select),
        .clk_out(proc_clk_out),
        .ready(proc_rdy)
    );

    mpc_clkdiv #(.CNT_W(2)) u_mst_div (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .src_level(proc_clk_out),
        .restart(mck_restart),
        .div_code(master_divide_code),
        .clk_out(master_clk_out),
        .ready(mst_rdy)
    );

    for (genvar g = 0; g < NUM_PCK; g++) begin : g_pck
        assign pck_view[g] = mpc_pck_cfg_t'(pck_cfg_reg[g][4:0]);
        mpc_clkdiv #(.CNT_W(6)) u_pck_div (
            .sys_clk(sys_clk),
            .nrst(nrst),
            .src_level(src_vec[pck_view[g].clock_source_select]),
            .restart(pck_restart[g]),
            .div_code(pck_view[g].prescaler_select),
            .clk_out(prog_clk_out[g]),
            .ready(pck_rdy[g])
        );
    end

    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign main_osc_enable = osc_ctrl_reg[OSC_EN_BIT];
    assign pll_a_pump_current = pump_reg[PUMP_A_BIT];
    assign pll_b_pump_current = pump_reg[PUMP_B_BIT];
    assign irq = |(status_word & irq_en_reg);
endmodule
`default_nettype wire

// ### testbench/mpc_src_model.sv
// Free-running slow, main and two PLL source clocks
`timescale 1ns/1ps
`default_nettype none
module mpc_src_model
    import mpc_pkg::*;
(
    input wire logic sys_clk,
    output var mpc_pkg::mpc_src_t src_out
);
    int cnt = 0;
    function automatic logic half(input int c, input int h);
        return ((c / h) % 2) != 0;
    endfunction
    always_ff @(posedge sys_clk) begin
        cnt <= cnt + 1;
    end
    // Periods 16, 4, 6 and 8 system cycles
    assign src_out = {half(cnt, 4), half(cnt, 3), half(cnt, 2), half(cnt, 8)};
endmodule
`default_nettype wire

// ### testbench/mpc_top_properties.sv
// Checker of bus timing, clock outputs and interrupt level
`timescale 1ns/1ps
`default_nettype none
module mpc_top_properties
    import mpc_pkg::*;
(
    input wire logic sys_clk,
    input wire logic nrst,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_rresp,
    input wire logic proc_clk_out,
    input wire logic master_clk_out,
    input wire logic pll_a_pump_current,
    input wire logic pll_b_pump_current,
    input wire logic irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response not on time");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not on time");
    a_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write accepted during response");
    a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read accepted during data");
    a_status_okay: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == STATUS_ADDR
        |=> s_axi_rresp == RESP_OKAY) else $error("status read refused");
    a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 32'h0FFF_FD00
        |=> s_axi_rresp == RESP_SLVERR) else $error("unmapped read accepted");
    a_pump_follow: assert property ($changed(pll_a_pump_current) || $changed(pll_b_pump_current)
        |-> $rose(s_axi_bvalid)) else $error("pump output moved without write");
    a_master_follow: assert property ($rose(master_clk_out)
        |-> $past(proc_clk_out) || $past(proc_clk_out, 2) || $past(proc_clk_out, 3))
        else $error("master clock rose without processor clock");
    a_irq_reset: assert property ($rose(nrst) |-> !irq)
        else $error("interrupt high after reset");
endmodule
bind mpc_top mpc_top_properties u_props (.*);
`default_nettype wire

// ### testbench/mpc_top_tb.sv
// Register-level regression of the clock selection block
`timescale 1ns/1ps
`default_nettype none
module mpc_top_tb;
    import mpc_pkg::*;
    logic sys_clk, nrst, awvalid, wvalid, bvalid, arvalid, rvalid, awready, wready, arready, bready, rready;
    logic proc, mck, osc_en, pa, pb, irq;
    logic [31:0] awaddr, wdata, araddr, rdata, rd;
    logic [3:0] wstrb, pck;
    logic [1:0] bresp, rresp, rs;
    logic [5:0] clk_vec;
    mpc_src_t src;
    int error_cnt, check_count, n;
    int src_per[4] = '{16, 4, 6, 8};
    assign clk_vec = {pck, mck, proc};
    mpc_src_model u_src (.sys_clk(sys_clk), .src_out(src));
    mpc_top u_dut (.sys_clk(sys_clk), .nrst(nrst), .src_in(src), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .proc_clk_out(proc),
        .master_clk_out(mck), .prog_clk_out(pck), .main_osc_enable(osc_en), .pll_a_pump_current(pa),
        .pll_b_pump_current(pb), .irq(irq));
    initial begin
        sys_clk = 0;
        forever #12.5 sys_clk = ~sys_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic aw_hit, w_hit, b_hit;
        int k;
        b_hit = 0;
        k = 0;
        @(posedge sys_clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        while (!b_hit && k < 1000) begin
            @(negedge sys_clk);
            aw_hit = awvalid && awready;
            w_hit = wvalid && wready;
            b_hit = bvalid === 1'b1;
            rs = bresp;
            k++;
            @(posedge sys_clk);
            if (aw_hit) awvalid <= 0;
            if (w_hit) wvalid <= 0;
        end
        bready <= 0;
        if (!b_hit) chk("bvalid_wait", 32'h1, 32'h0);
    endtask
    task automatic rd_reg(input logic [31:0] a);
        logic ar_hit, r_hit;
        int k;
        r_hit = 0;
        k = 0;
        @(posedge sys_clk);
        araddr <= a;
        arvalid <= 1;
        rready <= 1;
        while (!r_hit && k < 1000) begin
            @(negedge sys_clk);
            ar_hit = arvalid && arready;
            r_hit = rvalid === 1'b1;
            rd = rdata;
            rs = rresp;
            k++;
            @(posedge sys_clk);
            if (ar_hit) arvalid <= 0;
        end
        rready <= 0;
        if (!r_hit) chk("rvalid_wait", 32'h1, 32'h0);
    endtask
    task automatic rc(input logic [31:0] a, input logic [31:0] e, input string nm);
        rd_reg(a);
        chk(nm, e, rd);
    endtask
    // Cycles between two rising edges of one output clock, 0 if none
    task automatic per(input int k, output int p);
        logic prev, cur;
        int t, c;
        t = 0;
        c = 0;
        p = 0;
        prev = 1;
        while (c < 2 && t < 3000) begin
            @(negedge sys_clk);
            cur = clk_vec[k];
            if (cur === 1'b1 && prev === 1'b0) c++;
            if (c == 1) p++;
            prev = cur;
            t++;
        end
    endtask
    task automatic print_verdict;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (40000) @(posedge sys_clk);
        error_cnt++;
        print_verdict();
    end
    initial begin
        nrst = 0;
        {awaddr, wdata, araddr, awvalid, wvalid, arvalid, bready, rready} = '0;
        wstrb = 4'hF;
        repeat (8) @(posedge sys_clk);
        nrst <= 1;
        rc(MCK_CFG_ADDR, MCK_CFG_RST, "mck_cfg");
        rc(PUMP_ADDR, PUMP_RST, "pump");
        rc(MASK_VIEW_ADDR, 32'h0000_0F0F, "mask_rst");
        rc(IRQ_SET_ADDR, 32'h0, "ier_read");
        chk("irq_rst", 32'h0, {31'h0, irq});
        $display("test reset done");
        wr(MCK_CFG_ADDR, 32'hFFFF_FFFF);
        rc(MCK_CFG_ADDR, MCK_WMASK, "mck_bits");
        for (int s = 0; s < 4; s++) begin
            wr(MCK_CFG_ADDR, {22'h0, 2'h1, 3'h0, 3'h1, s[1:0]});
            per(0, n);
            chk("proc_per", 2 * src_per[s], n);
            per(1, n);
            chk("mck_per", 4 * src_per[s], n);
        end
        for (int p = 0; p < 7; p += 3) begin
            wr(MCK_CFG_ADDR, {22'h0, 2'h0, 3'h0, p[2:0], 2'h1});
            rd_reg(STATUS_ADDR);
            if (p == 6) chk("mck_rdy_clr", 32'h0, {31'h0, rd[ST_MCK_RDY]});
            per(0, n);
            chk("prescaler_select_per", src_per[1] << p, n);
        end
        rd_reg(STATUS_ADDR);
        chk("mck_rdy_set", 32'h1, {31'h0, rd[ST_MCK_RDY]});
        wr(MCK_CFG_ADDR, 32'h0000_001D);
        per(0, n);
        chk("prescaler_select_rsv", 32'h0, n);
        wr(MCK_CFG_ADDR, 32'h0000_0301);
        per(1, n);
        chk("master_divide_rsv", 32'h0, n);
        $display("test master clock done");
        for (int i = 0; i < 4; i++) begin
            wr(PCK_CFG_ADDR + WORD_STEP * i, {27'h0, 3'h1, i[1:0]});
            per(2 + i, n);
            chk("pck_per", 2 * src_per[i], n);
        end
        rc(STATUS_ADDR, 32'h0000_0F06, "pck_rdy");
        wr(PCK_CFG_ADDR, 32'h0000_0019);
        per(2, n);
        chk("pck_prescaler_select", 32'd256, n);
        $display("test programmable clocks done");
        wr(IRQ_SET_ADDR, 32'h0000_0002);
        rc(MASK_VIEW_ADDR, 32'h0000_0F0D, "mask_set");
        chk("irq_on", 32'h1, {31'h0, irq});
        wr(IRQ_SET_ADDR, 32'h0);
        rc(MASK_VIEW_ADDR, 32'h0000_0F0D, "mask_zero");
        wr(PLL_A_CFG_ADDR, 32'h0000_0300);
        chk("irq_unlock", 32'h0, {31'h0, irq});
        rc(STATUS_ADDR, 32'h0000_0F04, "lock_clr");
        repeat (60) @(posedge sys_clk);
        rc(STATUS_ADDR, 32'h0000_0F06, "lock_set");
        chk("irq_relock", 32'h1, {31'h0, irq});
        wr(IRQ_CLR_ADDR, 32'h0000_0002);
        rc(MASK_VIEW_ADDR, 32'h0000_0F0F, "mask_clr");
        chk("irq_off", 32'h0, {31'h0, irq});
        wr(IRQ_SET_ADDR, 32'hFFFF_FFFF);
        rc(MASK_VIEW_ADDR, 32'h0, "mask_all");
        wr(IRQ_CLR_ADDR, 32'hFFFF_FFFF);
        rc(MASK_VIEW_ADDR, 32'h0000_0F0F, "mask_none");
        $display("test interrupts done");
        wr(OSC_CTRL_ADDR, 32'h0000_0201);
        chk("osc_en", 32'h1, {31'h0, osc_en});
        repeat (150) @(posedge sys_clk);
        rc(STATUS_ADDR, 32'h0000_0F06, "osc_wait");
        repeat (150) @(posedge sys_clk);
        rc(STATUS_ADDR, 32'h0000_0F07, "osc_stable");
        $display("test oscillator done");
        wr(PUMP_ADDR, 32'hFFFF_FFFF);
        rc(PUMP_ADDR, PUMP_WMASK, "pump_bits");
        chk("pump_out", 32'h3, {30'h0, pa, pb});
        rd_reg(32'h0FFF_FD00);
        chk("unmap_rd", 32'h0, rd);
        chk("unmap_rresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        wr(32'h0FFF_FD00, 32'h1);
        chk("unmap_bresp", {30'h0, RESP_SLVERR}, {30'h0, rs});
        $display("test pump and map done");
        print_verdict();
    end
endmodule
`default_nettype wire
